// ==== rtl/asvm_line_if.sv ====
// Per-line horizontal figures handed from the line counter to the frame logic.
interface asvm_line_if import asvm_pkg::*; ();
   logic         tick;
   logic         seen;
   asvm_cnt_type vid_begin;
   asvm_cnt_type vid_stop;
   asvm_cnt_type period;
   asvm_cnt_type pulse;
   modport src (output tick, output seen, output vid_begin, output vid_stop,
                output period, output pulse);
   modport snk (input tick, input seen, input vid_begin, input vid_stop,
                input period, input pulse);
endinterface

// ==== rtl/asvm_line_meas.sv ====
// Horizontal line counter: video start, end, period and flyback width per line.
`include "asvm_params.svh"
module asvm_line_meas import asvm_pkg::*; (
   input  wire logic   clk_sys,
   input  wire logic   rst_n,
   input  wire logic   flb,
   input  wire logic   vid,
   asvm_line_if.src    line
);
   logic         flb_q;
   logic         vid_q;
   logic         seen_q;
   asvm_cnt_type pos_q;
   asvm_cnt_type per_q;
   asvm_cnt_type pw_q;
   asvm_cnt_type beg_q;
   asvm_cnt_type stop_q;

   // =========================================================
   // Flyback edges and line hand-over
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flb_q          <= 1'b0;
         per_q          <= `ASVM_RST_CNT;
         pw_q           <= `ASVM_RST_CNT;
         line.tick      <= 1'b0;
         line.seen      <= 1'b0;
         line.vid_begin <= `ASVM_RST_CNT;
         line.vid_stop  <= `ASVM_RST_CNT;
         line.period    <= `ASVM_RST_CNT;
         line.pulse     <= `ASVM_RST_CNT;
      end else begin
         flb_q     <= flb;
         line.tick <= flb && !flb_q;
         if (flb && !flb_q) begin
            line.seen      <= seen_q;
            line.vid_begin <= beg_q;
            line.vid_stop  <= stop_q;
            line.period    <= per_q;
            line.pulse     <= pw_q;
            per_q          <= 12'h001;
         end else begin
            per_q <= asvm_sat_inc(per_q);
         end
         if (!flb && flb_q) begin
            pw_q <= per_q;
         end
      end
   end

   // =========================================================
   // Video edges measured from the flyback trailing edge
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vid_q  <= 1'b0;
         seen_q <= 1'b0;
         pos_q  <= `ASVM_RST_CNT;
         beg_q  <= `ASVM_RST_CNT;
         stop_q <= `ASVM_RST_CNT;
      end else begin
         vid_q <= vid;
         if (!flb && flb_q) begin
            pos_q  <= `ASVM_RST_CNT;
            seen_q <= 1'b0;
         end else begin
            pos_q <= asvm_sat_inc(pos_q);
            if (!flb && !flb_q && vid && !vid_q && !seen_q) begin
               beg_q  <= pos_q;
               seen_q <= 1'b1;
            end
            if (!flb && !flb_q && !vid && vid_q && seen_q) begin
               stop_q <= pos_q;
            end
         end
      end
   end
endmodule

// ==== rtl/asvm_params.svh ====
// Offsets, field positions and reset values of the auto sizing measurement unit.
`ifndef ASVM_PARAMS_SVH
`define ASVM_PARAMS_SVH
`define ASVM_OFF_RES0  8'h00
`define ASVM_OFF_RES1  8'h01
`define ASVM_OFF_RES2  8'h02
`define ASVM_OFF_RES3  8'h03
`define ASVM_OFF_RES4  8'h04
`define ASVM_OFF_RES5  8'h05
`define ASVM_OFF_RES6  8'h06
`define ASVM_OFF_RES7  8'h07
`define ASVM_OFF_RES8  8'h08
`define ASVM_OFF_RES9  8'h09
`define ASVM_OFF_RES10 8'h0A
`define ASVM_OFF_RES11 8'h0B
`define ASVM_OFF_RES12 8'h0C
`define ASVM_OFF_RES13 8'h0D
`define ASVM_OFF_CTRL  8'h10
`define ASVM_OFF_POL   8'h11
`define ASVM_BIT_DONE  7
`define ASVM_BIT_OVER  4
`define ASVM_BIT_GO    7
`define ASVM_BIT_HSP   3
`define ASVM_BIT_VSP   2
`define ASVM_BIT_VPOL  0
`define ASVM_RST_TRIG  3'h0
`define ASVM_RST_POL   1'h0
`define ASVM_RST_HMIN  12'hFFF
`define ASVM_RST_CNT   12'h000
`endif

// ==== rtl/asvm_pkg.sv ====
// Types and shared arithmetic of the auto sizing measurement unit.
package asvm_pkg;
   typedef logic [11:0] asvm_cnt_type;
   typedef enum logic [1:0] {asvm_st_idle, asvm_st_arm, asvm_st_run} asvm_state_type;

   // Counters stick at full scale so a runaway line never wraps to a small figure.
   function automatic asvm_cnt_type asvm_sat_inc(input asvm_cnt_type v);
      asvm_cnt_type r;
      r = (v == 12'hFFF) ? v : asvm_cnt_type'(v + 12'h001);
      return r;
   endfunction
endpackage

// ==== rtl/asvm_sync.sv ====
// Two-stage synchroniser for the flyback and video comparator pins.
module asvm_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// ==== rtl/asvm_top.sv ====
// Auto sizing video measurement unit: frame control, results and register port.
`include "asvm_params.svh"

module asvm_top import asvm_pkg::*; (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       hflb_pin,
   input  wire logic       vflb_pin,
   input  wire logic       rin_pin,
   input  wire logic       gin_pin,
   input  wire logic       bin_pin,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic      [2:0] trigger_level_code
);
   // =========================================================
   // Declarations
   logic [4:0]     pins_s;
   logic           hsync_polarity_sel;
   logic           vsync_polarity_sel;
   logic           video_polarity_sel;
   logic           hflb;
   logic           vflb;
   logic           vid;
   logic           vflb_q;
   logic           vflb_rise;
   logic           ctrl_wr;
   logic           pol_wr;
   logic           go_set;
   logic           commit;
   logic           measure_go;
   logic           done_q;
   asvm_state_type state_q;
   asvm_cnt_type   line_cnt_q;
   logic           over_q;
   logic           any_q;
   asvm_cnt_type   hmin_q;
   asvm_cnt_type   hmax_q;
   asvm_cnt_type   vfirst_q;
   asvm_cnt_type   vlast_q;
   asvm_cnt_type   per_q;
   asvm_cnt_type   pw_q;
   asvm_cnt_type   line_video_begin_q;
   asvm_cnt_type   line_video_stop_q;
   asvm_cnt_type   line_period_dots_q;
   asvm_cnt_type   hsync_pulse_width_q;
   asvm_cnt_type   frame_video_first_line_q;
   asvm_cnt_type   frame_video_last_line_q;
   asvm_cnt_type   frame_line_total_q;
   logic           result_over_q;
   logic [7:0]     rdata_d;

   asvm_line_if line_bus ();

   // =========================================================
   // Input conditioning
   asvm_sync #(
      .W (5)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .async_in ({hflb_pin, vflb_pin, rin_pin, gin_pin, bin_pin}),
      .sync_out (pins_s)
   );

   // A select opposite to the pin polarity makes the flyback read high here.
   assign hflb = pins_s[4] ^ hsync_polarity_sel;
   assign vflb = pins_s[3] ^ vsync_polarity_sel;
   assign vid  = |(pins_s[2:0] ^ {3{video_polarity_sel}});

   asvm_line_meas u_line (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .flb     (hflb),
      .vid     (vid),
      .line    (line_bus.src)
   );

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vflb_q <= 1'b0;
      end else begin
         vflb_q <= vflb;
      end
   end

   assign vflb_rise = vflb && !vflb_q;
   assign ctrl_wr   = reg_wr && (reg_addr == `ASVM_OFF_CTRL);
   assign pol_wr    = reg_wr && (reg_addr == `ASVM_OFF_POL);
   assign go_set    = ctrl_wr && reg_wdata[`ASVM_BIT_GO];
   assign commit    = (state_q == asvm_st_run) && vflb_rise;

   // =========================================================
   // Control and polarity registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         trigger_level_code <= `ASVM_RST_TRIG;
      end else if (ctrl_wr) begin
         trigger_level_code <= reg_wdata[2:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hsync_polarity_sel <= `ASVM_RST_POL;
         vsync_polarity_sel <= `ASVM_RST_POL;
         video_polarity_sel <= `ASVM_RST_POL;
      end else if (pol_wr) begin
         hsync_polarity_sel <= reg_wdata[`ASVM_BIT_HSP];
         vsync_polarity_sel <= reg_wdata[`ASVM_BIT_VSP];
         video_polarity_sel <= reg_wdata[`ASVM_BIT_VPOL];
      end
   end

   // Writing zero to go does not abort a run; only completion clears it.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         measure_go <= 1'b0;
      end else if (go_set) begin
         measure_go <= 1'b1;
      end else if (commit) begin
         measure_go <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         done_q <= 1'b0;
      end else if (commit) begin
         done_q <= 1'b1;
      end else if (go_set) begin
         done_q <= 1'b0;
      end
   end

   // =========================================================
   // Frame sequencing
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= asvm_st_idle;
      end else begin
         case (state_q)
            asvm_st_idle: begin
               if (measure_go) begin
                  state_q <= asvm_st_arm;
               end
            end
            asvm_st_arm: begin
               if (vflb_rise) begin
                  state_q <= asvm_st_run;
               end
            end
            asvm_st_run: begin
               if (vflb_rise) begin
                  state_q <= asvm_st_idle;
               end
            end
            default: begin
               state_q <= asvm_st_idle;
            end
         endcase
      end
   end

   // =========================================================
   // Frame accumulation
   // A line ending on the same edge as the closing flyback is not counted in the frame.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_cnt_q <= `ASVM_RST_CNT;
         over_q     <= 1'b0;
         any_q      <= 1'b0;
         hmin_q     <= `ASVM_RST_HMIN;
         hmax_q     <= `ASVM_RST_CNT;
         vfirst_q   <= `ASVM_RST_CNT;
         vlast_q    <= `ASVM_RST_CNT;
         per_q      <= `ASVM_RST_CNT;
         pw_q       <= `ASVM_RST_CNT;
      end else if (state_q == asvm_st_arm && vflb_rise) begin
         line_cnt_q <= `ASVM_RST_CNT;
         over_q     <= 1'b0;
         any_q      <= 1'b0;
         hmin_q     <= `ASVM_RST_HMIN;
         hmax_q     <= `ASVM_RST_CNT;
         vfirst_q   <= `ASVM_RST_CNT;
         vlast_q    <= `ASVM_RST_CNT;
      end else if (state_q == asvm_st_run && line_bus.tick && !commit) begin
         line_cnt_q <= asvm_sat_inc(line_cnt_q);
         per_q      <= line_bus.period;
         pw_q       <= line_bus.pulse;
         if (line_cnt_q == 12'hFFF) begin
            over_q <= 1'b1;
         end
         if (line_bus.seen) begin
            any_q   <= 1'b1;
            vlast_q <= line_cnt_q;
            if (!any_q) begin
               vfirst_q <= line_cnt_q;
            end
            if (line_bus.vid_begin < hmin_q) begin
               hmin_q <= line_bus.vid_begin;
            end
            if (line_bus.vid_stop > hmax_q) begin
               hmax_q <= line_bus.vid_stop;
            end
         end
      end
   end

   // =========================================================
   // Result registers
   // All figures move together at the closing flyback, never part way through a frame.
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         line_video_begin_q       <= `ASVM_RST_CNT;
         line_video_stop_q        <= `ASVM_RST_CNT;
         line_period_dots_q       <= `ASVM_RST_CNT;
         hsync_pulse_width_q      <= `ASVM_RST_CNT;
         frame_video_first_line_q <= `ASVM_RST_CNT;
         frame_video_last_line_q  <= `ASVM_RST_CNT;
         frame_line_total_q       <= `ASVM_RST_CNT;
         result_over_q            <= 1'b0;
      end else if (commit) begin
         line_video_begin_q       <= hmin_q;
         line_video_stop_q        <= hmax_q;
         line_period_dots_q       <= per_q;
         hsync_pulse_width_q      <= pw_q;
         frame_video_first_line_q <= vfirst_q;
         frame_video_last_line_q  <= vlast_q;
         frame_line_total_q       <= line_cnt_q;
         result_over_q            <= over_q;
      end
   end

   // =========================================================
   // Register read port
   // Result offsets have no write path at all.
   always_comb begin
      rdata_d = 8'h00;
      if (reg_addr == `ASVM_OFF_RES0) begin
         rdata_d[3:0]           = line_video_begin_q[11:8];
         rdata_d[`ASVM_BIT_DONE] = done_q;
      end else if (reg_addr == `ASVM_OFF_RES1) begin
         rdata_d = line_video_begin_q[7:0];
      end else if (reg_addr == `ASVM_OFF_RES2) begin
         rdata_d[3:0] = line_video_stop_q[11:8];
      end else if (reg_addr == `ASVM_OFF_RES3) begin
         rdata_d = line_video_stop_q[7:0];
      end else if (reg_addr == `ASVM_OFF_RES4) begin
         rdata_d[3:0] = line_period_dots_q[11:8];
      end else if (reg_addr == `ASVM_OFF_RES5) begin
         rdata_d = line_period_dots_q[7:0];
      end else if (reg_addr == `ASVM_OFF_RES6) begin
         rdata_d[3:0] = hsync_pulse_width_q[11:8];
      end else if (reg_addr == `ASVM_OFF_RES7) begin
         rdata_d = hsync_pulse_width_q[7:0];
      end else if (reg_addr == `ASVM_OFF_RES8) begin
         rdata_d[3:0] = frame_video_first_line_q[11:8];
      end else if (reg_addr == `ASVM_OFF_RES9) begin
         rdata_d = frame_video_first_line_q[7:0];
      end else if (reg_addr == `ASVM_OFF_RES10) begin
         rdata_d[3:0] = frame_video_last_line_q[11:8];
      end else if (reg_addr == `ASVM_OFF_RES11) begin
         rdata_d = frame_video_last_line_q[7:0];
      end else if (reg_addr == `ASVM_OFF_RES12) begin
         rdata_d[3:0]           = frame_line_total_q[11:8];
         rdata_d[`ASVM_BIT_OVER] = result_over_q;
      end else if (reg_addr == `ASVM_OFF_RES13) begin
         rdata_d = frame_line_total_q[7:0];
      end else if (reg_addr == `ASVM_OFF_CTRL) begin
         rdata_d[2:0]          = trigger_level_code;
         rdata_d[`ASVM_BIT_GO] = measure_go;
      end else if (reg_addr == `ASVM_OFF_POL) begin
         rdata_d[`ASVM_BIT_HSP]  = hsync_polarity_sel;
         rdata_d[`ASVM_BIT_VSP]  = vsync_polarity_sel;
         rdata_d[`ASVM_BIT_VPOL] = video_polarity_sel;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // =========================================================
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_run_start_flyback: assert property (
      (state_q == asvm_st_arm && vflb_rise) |=> (state_q == asvm_st_run)
   ) else $error("Run did not start at the vertical flyback.");

   a_run_end_done: assert property (
      commit |=> (done_q && state_q == asvm_st_idle)
   ) else $error("Run end did not raise done.");

   a_go_self_clear: assert property (
      (commit && !go_set) |=> !measure_go
   ) else $error("Go bit not cleared after the frame.");

   a_done_cleared_go: assert property (
      (go_set && !commit) |=> !done_q
   ) else $error("Done flag not cleared by a new go.");

   a_done_readback: assert property (
      (reg_addr == `ASVM_OFF_RES0) |=> (reg_rdata[`ASVM_BIT_DONE] == $past(done_q))
   ) else $error("Done flag read back wrong.");

   a_trig_by_write: assert property (
      !$stable(trigger_level_code) |-> $past(ctrl_wr)
   ) else $error("Trigger level moved without a write.");

   a_line_count_step: assert property (
      (state_q == asvm_st_run && line_bus.tick && !commit && line_cnt_q != 12'hFFF)
      |=> (line_cnt_q == asvm_cnt_type'($past(line_cnt_q) + 12'h001))
   ) else $error("Line counter did not step on a line.");

   a_hmin_keeps: assert property (
      (state_q == asvm_st_run && line_bus.tick && line_bus.seen && !commit)
      |=> (hmin_q <= $past(line_bus.vid_begin) && hmin_q <= $past(hmin_q))
   ) else $error("Minimum start not kept.");

   a_hmax_keeps: assert property (
      (state_q == asvm_st_run && line_bus.tick && line_bus.seen && !commit)
      |=> (hmax_q >= $past(line_bus.vid_stop) && hmax_q >= $past(hmax_q))
   ) else $error("Maximum end not kept.");

   a_first_line: assert property (
      (state_q == asvm_st_run && line_bus.tick && line_bus.seen && !any_q && !commit)
      |=> (vfirst_q == $past(line_cnt_q))
   ) else $error("First video line not captured.");

   a_over_set: assert property (
      (state_q == asvm_st_run && line_bus.tick && !commit && line_cnt_q == 12'hFFF)
      |=> over_q
   ) else $error("Line overflow not flagged.");

   a_result_store: assert property (
      commit |=> (line_video_begin_q == $past(hmin_q) && frame_line_total_q == $past(line_cnt_q))
   ) else $error("Results not stored at run end.");

   a_result_hold: assert property (
      !commit |=> ($stable(line_video_begin_q) && $stable(frame_line_total_q) &&
                   $stable(result_over_q))
   ) else $error("Result changed outside run end.");
endmodule

// ==== tb/asvm_video_src.sv ====
// Monitor-side model: flyback pulses and comparator outputs, one dot per clk_sys.
module asvm_video_src (
   input  wire logic clk_sys,
   input  int        cfg [8],
   output logic      hflb_pin,
   output logic      vflb_pin,
   output logic      rin_pin,
   output logic      gin_pin,
   output logic      bin_pin,
   output logic      cur_inv
);
   timeunit 1ns;
   timeprecision 1ns;
   // Settings are taken only at a frame start, so a run never sees a torn frame.
   int k [8] = '{8, 2, 0, 0, 3, 50, -10, 0};
   int m     = 0;
   int c     = 0;
   assign cur_inv = k[7][0];
   initial {hflb_pin, vflb_pin, rin_pin, gin_pin, bin_pin} = 5'h00;
   always @(negedge clk_sys) begin
      if (c >= k[0] - 1) begin
         c = 0;
         if (m >= k[4] - 1) begin
            m = 0;
            k = cfg;
         end else begin
            m++;
         end
      end else begin
         c++;
      end
      // Inverted pins pair with polarity selects that the bench sets opposite.
      hflb_pin <= (c < k[1]) ^ k[7][0];
      vflb_pin <= (m == k[4] - 1 && c >= k[1] + 2) ^ k[7][0];
      rin_pin  <= (m >= k[5] && m <= k[6] && c >= k[1] + k[2] && c <= k[1] + k[3]) ^ k[7][0];
      gin_pin  <= (m == k[5] + 1 && c >= k[1] + k[2] - 2 && c <= k[1] + k[2]) ^ k[7][0];
      bin_pin  <= (m == k[6] && c >= k[1] + k[3] && c <= k[1] + k[3] + 3) ^ k[7][0];
   end
endmodule

// ==== tb/tb_auto_sizing_video_measure.sv ====
// Self-checking bench of the auto sizing video measurement unit.
`include "asvm_params.svh"
module tb_auto_sizing_video_measure import asvm_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {
      int           cfg [8];
      logic [2:0]   trig;
      asvm_cnt_type fig [7];
   } asvm_row_type;
   // ==========================================================
   // Rows: source settings beside the figures they should give.
   // Edge positions count from the second dot after the flyback ends, and the
   // line segment opened by the vertical flyback is line zero.
   asvm_row_type rows [3] = '{
      '{'{300, 20, 10, 200, 12, 2, 8, 0}, 3'h5,
        '{12'h007, 12'h0CB, 12'h12C, 12'h014, 12'h003, 12'h009, 12'h00C}},
      '{'{300, 20, 10, 200, 12, 2, 8, 1}, 3'h7,
        '{12'h007, 12'h0CB, 12'h12C, 12'h014, 12'h003, 12'h009, 12'h00C}},
      '{'{520, 40, 100, 450, 10, 1, 8, 0}, 3'h2,
        '{12'h061, 12'h1C5, 12'h208, 12'h028, 12'h002, 12'h009, 12'h00A}}};
   asvm_row_type ovr = '{'{6, 2, 0, 0, 4100, 5000, -10, 0}, 3'h0,
      '{12'hFFF, 12'h000, 12'h006, 12'h002, 12'h000, 12'h000, 12'hFFF}};
   logic       clk_sys, rst_n, hflb_pin, vflb_pin, rin_pin, gin_pin, bin_pin, cur_inv;
   logic       reg_wr;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic [2:0] trigger_level_code;
   logic [3:0] prev_hi;
   int         cfg [8];
   int         error_cnt;
   int         checks_done;
   asvm_top i_asvm_top (.clk_sys, .rst_n, .hflb_pin, .vflb_pin, .rin_pin, .gin_pin,
      .bin_pin, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .trigger_level_code);
   asvm_video_src i_asvm_video_src (.clk_sys, .cfg, .hflb_pin, .vflb_pin, .rin_pin,
      .gin_pin, .bin_pin, .cur_inv);
   // ==========================================================
   // Register port and comparison tasks.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      @(negedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic cmp(input logic [7:0] g, input logic [7:0] x);
      checks_done++;
      if (g !== x) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   function automatic logic [7:0] ex(input asvm_row_type r, input int i, input logic ov);
      asvm_cnt_type f;
      f = r.fig[i / 2];
      if (i % 2 == 1) return f[7:0];
      return {(i == 0), 2'h0, (i == 12) && ov, f[11:8]};
   endfunction
   task automatic chk_all(input asvm_row_type r, input logic ov);
      for (int i = 0; i < 14; i++) begin
         rd(8'(i), v);
         cmp(v, ex(r, i, ov));
      end
   endtask
   // A late row swaps the source only after the arming flyback, so the run
   // frame is the long one without waiting a whole long frame to arm.
   task automatic run(input asvm_row_type r, input logic late);
      int i;
      if (!late) cfg = r.cfg;
      wait (cur_inv === r.cfg[7][0]);
      wr(`ASVM_OFF_POL, {4'h0, r.cfg[7][0], r.cfg[7][0], 1'b0, r.cfg[7][0]});
      wr(`ASVM_OFF_CTRL, {1'b1, 4'h0, r.trig});
      rd(`ASVM_OFF_CTRL, v);
      cmp(v, {1'b1, 4'h0, r.trig});
      rd(`ASVM_OFF_RES0, v);
      cmp(v, {4'h0, prev_hi});
      if (late) begin
         @(posedge vflb_pin);
         @(posedge clk_sys);
         cfg = r.cfg;
      end
      i = 0;
      do begin
         rd(`ASVM_OFF_RES0, v);
         i++;
      end while (v[`ASVM_BIT_DONE] !== 1'b1 && i < 40000);
      cmp({7'h00, v[`ASVM_BIT_DONE]}, 8'h01);
      rd(`ASVM_OFF_CTRL, v);
      cmp(v, {5'h00, r.trig});
      chk_all(r, late);
      prev_hi = r.fig[0][11:8];
   endtask
   task automatic end_sim();
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and test sequence.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   // Rows take at most about 55k cycles, the overflow frame being almost half of it.
   initial begin
      #(80000 * 50);
      error_cnt++;
      end_sim();
   end
   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      prev_hi = 4'h0;
      cfg = rows[0].cfg;
      repeat (4) @(posedge clk_sys);
      cmp({5'h00, trigger_level_code}, 8'h00);
      @(negedge clk_sys);
      rst_n = 1'b1;
      foreach (ovr.fig[i]) begin
         rd(8'(i * 3 + 16 * (i % 2)), v);
         cmp(v, 8'h00);
      end
      for (int i = 0; i < 8; i++) begin
         wr(`ASVM_OFF_CTRL, {5'h00, 3'(i)});
         cmp({5'h00, trigger_level_code}, {5'h00, 3'(i)});
      end
      foreach (rows[j]) run(rows[j], 1'b0);
      for (int i = 0; i < 14; i++) wr(8'(i), 8'hA5);
      chk_all(rows[2], 1'b0);
      run(ovr, 1'b1);
      end_sim();
   end
endmodule
